// file: hdl/ssc_regs.sv
// Status, control, select-mask and end-of-packet registers of an SPI core.
// Assumes the shift datapath on the same clock hands words in and out, and
// the slave select input arrives from a pin in another timing domain.
module ssc_regs
  import ssc_pkg::*;
(
  input  wire logic                  MCLK_I,         // Bus clock.
  input  wire logic                  RESETN_I,       // Synchronous reset, active low.
  input  wire logic                  CE_I,           // Clock enable, freezes all state when low.
  input  wire logic [2:0]            ADDR_I,         // Register address.
  input  wire logic                  CS_I,           // Chip select.
  input  wire logic                  RD_I,           // Read strobe.
  input  wire logic                  WR_I,           // Write strobe.
  input  wire logic [DATA_WIDTH-1:0] WDATA_I,        // Write data.
  output logic      [DATA_WIDTH-1:0] RDATA_O,        // Read data, one cycle after the read.
  input  wire logic                  MASTER_I,       // High for master configuration.
  output logic      [DATA_WIDTH-1:0] TX_DATA_O,      // Held transmit word.
  output logic                       TX_VALID_O,     // Held transmit word present.
  input  wire logic                  TX_TAKE_I,      // Datapath moves held word to shifter.
  input  wire logic                  SHIFT_BUSY_I,   // Transfer in progress.
  input  wire logic                  RX_VALID_I,     // Complete received word.
  input  wire logic [DATA_WIDTH-1:0] RX_DATA_I,      // Received word.
  input  wire logic                  SS_N_I,         // Slave select pin, active low.
  output logic      [SEL_WIDTH-1:0]  SS_N_O,         // Select outputs, active low.
  output logic                       IRQ_O           // Level interrupt request.
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [10:0]           control;        // Enables and force-select.
  logic [SEL_WIDTH-1:0]  sel_mask;       // Software select mask.
  logic [SEL_WIDTH-1:0]  sel_latched;    // Mask as sampled for the outputs.
  logic [DATA_WIDTH-1:0] pkt_end_word;   // End-of-packet compare word.
  logic [DATA_WIDTH-1:0] rx_word;        // Received word register.
  logic [DATA_WIDTH-1:0] tx_word;        // Transmit holding word.
  logic                  tx_full;        // Holding register occupied.
  logic                  rx_full;        // Unread received word.
  logic                  rx_overrun;     // Sticky receive overrun.
  logic                  tx_overrun;     // Sticky transmit overrun.
  logic                  pkt_end;        // Sticky end-of-packet match.
  logic                  force_prev;     // Force-select of the previous cycle.
  logic                  ss_meta;        // First synchroniser stage.
  logic                  ss_sync;        // Synchronised slave select.
  ssc_access_type        acc;            // Decoded access.
  ssc_status_type        stat;           // Status flag group.
  logic [DATA_WIDTH-1:0] status_word;    // Status as read.
  logic [DATA_WIDTH-1:0] next_rdata;     // Read mux output.
  logic [SEL_WIDTH-1:0]  next_latched;   // Next sampled mask.
  logic [SEL_WIDTH-1:0]  sel_enable;     // Replicated select enable.
  logic [10:0]           irq_sources;    // Flags gated by enables.
  logic                  rd_rx;          // Read of the received word.
  logic                  wr_tx;          // Write of the transmit word.
  logic                  wr_status;      // Any status write.
  logic                  tx_accept;      // Transmit write accepted.
  logic                  tx_reject;      // Transmit write refused.
  logic                  rx_lost;        // Arrival over an unread word.
  logic                  pkt_hit;        // End-of-packet match this cycle.
  logic                  sel_sample;     // Mask sample moment.
  logic                  sel_drive;      // Select outputs active.

  // Decodes an access of one kind to one address.
  function automatic logic hit(input ssc_access_type a, input logic [2:0] where, input logic is_wr);
    hit = (a.addr == where) && (is_wr ? a.wr : a.rd);
  endfunction : hit

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------
  assign acc.rd   = CS_I & RD_I & CE_I;
  assign acc.wr   = CS_I & WR_I & CE_I;
  assign acc.addr = ADDR_I;

  assign rd_rx     = hit(acc, ADDR_RX_DATA, 1'b0);
  assign wr_tx     = hit(acc, ADDR_TX_DATA, 1'b1);
  assign wr_status = hit(acc, ADDR_STATUS, 1'b1);

  // Writes to the received word address are simply not decoded.
  assign tx_accept = wr_tx & ~tx_full;
  assign tx_reject = wr_tx & tx_full;
  assign rx_lost   = RX_VALID_I & CE_I & rx_full & ~rd_rx;
  assign pkt_hit   = (rd_rx && rx_word == pkt_end_word) ||
                     (wr_tx && WDATA_I == pkt_end_word);

  // ----------------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------------
  assign stat.rx_overrun  = rx_overrun;
  assign stat.tx_overrun  = tx_overrun;
  assign stat.tx_ready    = ~tx_full;
  assign stat.rx_ready    = rx_full;
  assign stat.pkt_end     = pkt_end;
  // Master: empty when no shift runs. Slave: not empty when selected or
  // when an unread word blocks the receive side.
  assign stat.shift_empty = MASTER_I ? ~SHIFT_BUSY_I
                                     : ~(~ss_sync | rx_full);

  // Reading the status word has no side effect on any flag.
  always_comb begin
    status_word                  = '0;
    status_word[BIT_RX_OVERRUN]  = stat.rx_overrun;
    status_word[BIT_TX_OVERRUN]  = stat.tx_overrun;
    status_word[BIT_SHIFT_EMPTY] = stat.shift_empty;
    status_word[BIT_TX_READY]    = stat.tx_ready;
    status_word[BIT_RX_READY]    = stat.rx_ready;
    status_word[BIT_ERROR]       = stat.rx_overrun | stat.tx_overrun;
    status_word[BIT_PKT_END]     = stat.pkt_end;
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Unmapped addresses and the write-only word read as zero.
  always_comb begin
    case (ADDR_I)
      ADDR_RX_DATA:  next_rdata = rx_word;
      ADDR_STATUS:   next_rdata = status_word;
      ADDR_CONTROL:  next_rdata = {21'h000000, control};
      ADDR_SEL_MASK: next_rdata = sel_mask;
      ADDR_PKT_END:  next_rdata = pkt_end_word;
      default:       next_rdata = '0;
    endcase
  end

  // Registered read data; holds its value between reads.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      RDATA_O <= WORD_RESET;
    end else if (acc.rd) begin
      RDATA_O <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  // Control, select mask and packet-end word; only writes change them.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      control      <= CONTROL_RESET;
      sel_mask     <= SEL_MASK_RESET;
      pkt_end_word <= WORD_RESET;
    end else begin
      if (hit(acc, ADDR_CONTROL, 1'b1)) begin
        control <= WDATA_I[10:0];
      end
      if (hit(acc, ADDR_SEL_MASK, 1'b1)) begin
        sel_mask <= WDATA_I;
      end
      if (hit(acc, ADDR_PKT_END, 1'b1)) begin
        pkt_end_word <= WDATA_I;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmit holding register
  // ----------------------------------------------------------------------
  // A refused write leaves the held word alone; the datapath take frees it.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      tx_word <= WORD_RESET;
      tx_full <= 1'b0;
    end else if (CE_I) begin
      if (tx_accept) begin
        tx_word <= WDATA_I;
        tx_full <= 1'b1;
      end else if (TX_TAKE_I) begin
        tx_full <= 1'b0;
      end
    end
  end

  assign TX_DATA_O  = tx_word;
  assign TX_VALID_O = tx_full;

  // ----------------------------------------------------------------------
  // Receive register
  // ----------------------------------------------------------------------
  // New words always replace the old one; an arrival in the read cycle wins.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      rx_word <= WORD_RESET;
      rx_full <= 1'b0;
    end else if (CE_I) begin
      if (RX_VALID_I) begin
        rx_word <= RX_DATA_I;
        rx_full <= 1'b1;
      end else if (rd_rx) begin
        rx_full <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------------
  // A status write clears them, but an event in the same cycle sets them.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      rx_overrun <= 1'b0;
      tx_overrun <= 1'b0;
      pkt_end    <= 1'b0;
    end else if (CE_I) begin
      rx_overrun <= rx_lost | (rx_overrun & ~wr_status);
      tx_overrun <= tx_reject | (tx_overrun & ~wr_status);
      pkt_end    <= pkt_hit | (pkt_end & ~wr_status);
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------------
  // Each status bit except shift-empty pairs with the control bit at the same position.
  assign irq_sources = status_word[10:0] & control & 11'h3D8;

  // Level output, held while any enabled flag stays set.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      IRQ_O <= 1'b0;
    end else if (CE_I) begin
      IRQ_O <= |irq_sources;
    end
  end

  // ----------------------------------------------------------------------
  // Slave select
  // ----------------------------------------------------------------------
  // Two-stage synchroniser for the select pin.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      ss_meta <= 1'b1;
      ss_sync <= 1'b1;
    end else if (CE_I) begin
      ss_meta <= SS_N_I;
      ss_sync <= ss_meta;
    end
  end

  // The mask is copied only at a transfer start or a force-select rise,
  // so software may rewrite it mid-transfer without glitching selects.
  assign sel_sample   = CE_I & (TX_TAKE_I | (control[BIT_FORCE_SEL] & ~force_prev));
  assign next_latched = sel_sample ? sel_mask : sel_latched;
  assign sel_drive    = MASTER_I & (control[BIT_FORCE_SEL] | SHIFT_BUSY_I);
  assign sel_enable   = {SEL_WIDTH{sel_drive}};

  // Latched mask and registered active-low outputs; slaves drive none.
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      sel_latched <= SEL_MASK_RESET;
      force_prev  <= 1'b0;
      SS_N_O      <= '1;
    end else if (CE_I) begin
      sel_latched <= next_latched;
      force_prev  <= control[BIT_FORCE_SEL];
      SS_N_O      <= ~(next_latched & sel_enable);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_error_or: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    status_word[BIT_ERROR] == (rx_overrun | tx_overrun))
    else $error("Error flag differs from overrun OR.");

  a_rx_overrun: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (CE_I && RX_VALID_I && rx_full && !rd_rx) |=> (rx_overrun && rx_word == $past(RX_DATA_I)))
    else $error("Receive overrun not flagged or word not replaced.");

  a_status_clear: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (wr_status && !rx_lost && !tx_reject) |=> (!rx_overrun && !tx_overrun && !status_word[BIT_ERROR]))
    else $error("Status write did not clear error flags.");

  a_tx_discard: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (wr_tx && tx_full) |=> (tx_overrun && $stable(tx_word)))
    else $error("Refused transmit write changed the held word.");

  a_tx_taken: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (wr_tx && !tx_full) |=> (!stat.tx_ready && tx_word == $past(WDATA_I)))
    else $error("Accepted transmit write left tx-ready high.");

  a_rx_read: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (rd_rx && !RX_VALID_I) |=> !rx_full)
    else $error("Receive read did not clear rx-ready.");

  a_irq_level: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (CE_I && (irq_sources != 11'h000)) |=> IRQ_O)
    else $error("Enabled flag did not raise interrupt.");

  a_force_sel: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (CE_I && MASTER_I && control[BIT_FORCE_SEL]) |=> (SS_N_O == ~sel_latched))
    else $error("Force-select did not drive masked selects.");

  a_mask_hold: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    !sel_sample |=> $stable(sel_latched))
    else $error("Select mask sampled outside its moments.");

  a_ctrl_read: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (acc.rd && !acc.wr) |=> $stable(control))
    else $error("Control read altered control.");

  // A running master shift or a selected slave must never read as empty.
  a_shift_empty: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    ((MASTER_I && SHIFT_BUSY_I) || (!MASTER_I && !ss_sync)) |-> !status_word[BIT_SHIFT_EMPTY])
    else $error("Shift-empty flag high while shifting or selected.");

  // A transmit word equal to the compare word leaves the packet-end flag set.
  a_pkt_match: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (wr_tx && WDATA_I == pkt_end_word) |=> pkt_end)
    else $error("Matching transmit word did not set packet-end.");

  // In slave configuration no select output may be driven active.
  a_slave_quiet: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (CE_I && !MASTER_I) |=> (&SS_N_O))
    else $error("Select output active in slave configuration.");

  c_rx_overrun: cover property (@(posedge MCLK_I) disable iff (!RESETN_I) rx_lost);
  c_tx_reject:  cover property (@(posedge MCLK_I) disable iff (!RESETN_I) tx_reject);
  c_pkt_end:    cover property (@(posedge MCLK_I) disable iff (!RESETN_I) pkt_hit ##1 IRQ_O);
  c_force_sel:  cover property (@(posedge MCLK_I) disable iff (!RESETN_I) sel_sample && !TX_TAKE_I);

endmodule : ssc_regs

// file: hdl/ssc_pkg.sv
// Package for the SPI status, control and slave-select register block.
// Assumes one bus clock domain; the shift datapath lives outside this block.
package ssc_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int DATA_WIDTH = 32;  // Width of receive and transmit words.
  localparam int SEL_WIDTH  = 32;  // Number of select outputs.

  // ----------------------------------------------------------------------
  // Internal register addresses
  // ----------------------------------------------------------------------
  localparam logic [2:0] ADDR_RX_DATA  = 3'h0;  // Received word, read only.
  localparam logic [2:0] ADDR_TX_DATA  = 3'h1;  // Transmit holding word, write only.
  localparam logic [2:0] ADDR_STATUS   = 3'h2;  // Status flags.
  localparam logic [2:0] ADDR_CONTROL  = 3'h3;  // Interrupt enables and force-select.
  localparam logic [2:0] ADDR_SEL_MASK = 3'h5;  // Select mask.
  localparam logic [2:0] ADDR_PKT_END  = 3'h6;  // End-of-packet word.

  // ----------------------------------------------------------------------
  // Bit positions shared by status and control
  // ----------------------------------------------------------------------
  localparam int BIT_RX_OVERRUN = 3;   // Receive overrun.
  localparam int BIT_TX_OVERRUN = 4;   // Transmit overrun.
  localparam int BIT_SHIFT_EMPTY = 5;  // Shift register empty, status only.
  localparam int BIT_TX_READY   = 6;   // Transmit holding register empty.
  localparam int BIT_RX_READY   = 7;   // Receive word waiting.
  localparam int BIT_ERROR      = 8;   // Either overrun.
  localparam int BIT_PKT_END    = 9;   // End-of-packet match.
  localparam int BIT_FORCE_SEL  = 10;  // Force-select, control only.

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [10:0]           CONTROL_RESET  = 11'h000;       // All enables off.
  localparam logic [SEL_WIDTH-1:0]  SEL_MASK_RESET = 32'h00000001;  // First slave.
  localparam logic [DATA_WIDTH-1:0] WORD_RESET     = 32'h00000000;  // Data words.

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  // Sticky and live status flags, grouped for the status word.
  typedef struct packed {
    logic pkt_end;
    logic rx_ready;
    logic tx_ready;
    logic shift_empty;
    logic tx_overrun;
    logic rx_overrun;
  } ssc_status_type;

  // One decoded register access.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
  } ssc_access_type;

endpackage : ssc_pkg

// file: bench/ssc_far_model.sv
// Far-side model: shift datapath with one loopback SPI device behind it.
// Assumes the bus clock; it drives its outputs at the falling edge.
module ssc_far_model (
  input  wire logic        clk_i,         // Bus clock.
  input  wire logic        stall_i,       // Holds off new transfers when high.
  input  wire logic        tx_valid_i,    // Held word present.
  input  wire logic [31:0] tx_data_i,     // Held word.
  output logic             tx_take_o,     // Held word moved into the shifter.
  output logic             shift_busy_o,  // Transfer running.
  output logic             rx_valid_o,    // Received word strobe.
  output logic      [31:0] rx_data_o      // Received word.
);
  timeunit 1ns;
  timeprecision 1ns;
  int          cnt  = 0;         // Cycles left in the running transfer.
  logic [31:0] word = 32'h0;     // Word in flight, echoed back when done.
  initial begin
    tx_take_o    = 1'h0;
    shift_busy_o = 1'h0;
    rx_valid_o   = 1'h0;
    rx_data_o    = 32'h0;
  end
  // Single data source, so several active selects never contend.
  always @(negedge clk_i) begin
    tx_take_o  <= 1'h0;
    rx_valid_o <= 1'h0;
    rx_data_o  <= ~rx_data_o;  // Idle data toggles so no stale word is seen.
    if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        shift_busy_o <= 1'h0;
        rx_valid_o   <= 1'h1;
        rx_data_o    <= word;
      end
    end else if (tx_valid_i && !stall_i && !tx_take_o) begin
      tx_take_o    <= 1'h1;
      shift_busy_o <= 1'h1;
      word         <= tx_data_i;
      cnt          <= 12;
    end
  end
endmodule : ssc_far_model

// file: bench/spi_status_control_regs_tb.sv
// Self-checking bench for the SPI status and control register block.
// Assumes the far-side model answers every taken word with an echo.
module spi_status_control_regs_tb;
  import ssc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        mclk = 1'h0, resetn = 1'h0, cs = 1'h0, rd = 1'h0, wr = 1'h0;
  logic        master = 1'h1, ss_n = 1'h1, stall = 1'h1;
  logic [2:0]  addr = 3'h0;
  logic [31:0] wdata = 32'h0, rdata, tx_data, rx_data, ss_n_out;
  logic        tx_valid, tx_take, busy, rx_valid, irq;
  int          bad_count = 0, compares = 0;
  always #5 mclk = ~mclk;
  ssc_regs DUT (.MCLK_I(mclk), .RESETN_I(resetn), .CE_I(1'h1), .ADDR_I(addr), .CS_I(cs),
    .RD_I(rd), .WR_I(wr), .WDATA_I(wdata), .RDATA_O(rdata), .MASTER_I(master),
    .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid), .TX_TAKE_I(tx_take), .SHIFT_BUSY_I(busy),
    .RX_VALID_I(rx_valid), .RX_DATA_I(rx_data), .SS_N_I(ss_n), .SS_N_O(ss_n_out), .IRQ_O(irq));
  ssc_far_model far (.clk_i(mclk), .stall_i(stall), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_take_o(tx_take), .shift_busy_o(busy), .rx_valid_o(rx_valid), .rx_data_o(rx_data));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // One write cycle, driven between falling edges.
  task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
    @(negedge mclk);
    cs = 1'h1; wr = 1'h1; addr = a; wdata = d;
    @(negedge mclk);
    cs = 1'h0; wr = 1'h0;
  endtask : wr_reg
  // One read cycle; data is checked half a cycle after the read edge.
  task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp, input string name);
    @(negedge mclk);
    cs = 1'h1; rd = 1'h1; addr = a;
    @(negedge mclk);
    cs = 1'h0; rd = 1'h0;
    chk(name, rdata, exp);
  endtask : rd_chk
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // Cuts a hang short after about 5000 cycles.
  initial begin
    #50000;
    bad_count++;
    results();
  end
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(negedge mclk);
    resetn = 1'h1;
    rd_chk(3'h3, 32'h0, "control");
    rd_chk(3'h5, 32'h1, "mask");
    rd_chk(3'h2, 32'h60, "status");
    chk("selects", ss_n_out, 32'hFFFFFFFF);
    wr_reg(3'h3, 32'h100);
    rd_chk(3'h3, 32'h100, "control");
    rd_chk(3'h3, 32'h100, "control");
    wr_reg(3'h6, 32'hA5A50001);
    rd_chk(3'h6, 32'hA5A50001, "pkt word");
    wr_reg(3'h5, 32'h6);
    // Held transfer: the matching word sets the packet flag.
    wr_reg(3'h1, 32'hA5A50001);
    chk("tx valid", {31'h0, tx_valid}, 32'h1);
    rd_chk(3'h2, 32'h220, "status");
    // A second word while full is dropped.
    wr_reg(3'h1, 32'h1234);
    chk("tx data", tx_data, 32'hA5A50001);
    rd_chk(3'h2, 32'h330, "status");
    chk("irq", {31'h0, irq}, 32'h1);
    wr_reg(3'h2, 32'hFFFFFFFF);
    rd_chk(3'h2, 32'h20, "status");
    chk("irq", {31'h0, irq}, 32'h0);
    // Release the far side; mask 6 is sampled at the start.
    wr_reg(3'h3, 32'h80);
    stall <= 1'h0;
    repeat (4) @(negedge mclk);
    chk("selects", ss_n_out, ~32'h6);
    rd_chk(3'h2, 32'h40, "status");
    wr_reg(3'h5, 32'h1);
    chk("selects", ss_n_out, ~32'h6);
    repeat (8) @(negedge mclk);
    chk("irq", {31'h0, irq}, 32'h1);
    chk("selects", ss_n_out, 32'hFFFFFFFF);
    rd_chk(3'h2, 32'hE0, "status");
    // Second word arrives unread: overrun, new word kept.
    wr_reg(3'h1, 32'hC3);
    repeat (16) @(negedge mclk);
    rd_chk(3'h2, 32'h1E8, "status");
    wr_reg(3'h0, 32'hFFFFFFFF);
    wr_reg(3'h6, 32'hC3);
    rd_chk(3'h0, 32'hC3, "rx word");
    rd_chk(3'h2, 32'h368, "status");
    chk("irq", {31'h0, irq}, 32'h0);
    // Forced selects take the mask at the rise of force.
    wr_reg(3'h5, 32'h8);
    wr_reg(3'h3, 32'h400);
    @(negedge mclk);
    chk("selects", ss_n_out, ~32'h8);
    rd_chk(3'h3, 32'h400, "control");
    // Slave configuration: selected pin empties nothing.
    wr_reg(3'h3, 32'h0);
    wr_reg(3'h2, 32'h0);
    master = 1'h0;
    ss_n = 1'h0;
    repeat (3) @(negedge mclk);
    rd_chk(3'h2, 32'h40, "status");
    chk("selects", ss_n_out, 32'hFFFFFFFF);
    ss_n = 1'h1;
    repeat (3) @(negedge mclk);
    rd_chk(3'h2, 32'h60, "status");
    // Second reset in mid-run, with enables and force-select set first.
    master = 1'h1;
    wr_reg(3'h3, 32'h7D8);
    @(negedge mclk);
    chk("irq", {31'h0, irq}, 32'h1);
    chk("selects", ss_n_out, ~32'h8);
    resetn = 1'h0;
    @(negedge mclk);
    resetn = 1'h1;
    chk("irq", {31'h0, irq}, 32'h0);
    chk("selects", ss_n_out, 32'hFFFFFFFF);
    rd_chk(3'h3, 32'h0, "control");
    rd_chk(3'h5, 32'h1, "mask");
    results();
  end
endmodule : spi_status_control_regs_tb
